// [rtl/relay_logic_equation_engine.v]
// Programmable relay logic engine with operand flags, element timers and breaker control timers.
`timescale 1ns/10ps
`include "relay_logic_map.vh"
module relay_logic_equation_engine #(
  parameter MS_CYCLES = `MS_CYCLES
) (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // Register port.
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdData,
  // Pins from the field.
  input wire [3:0] contIn,
  input wire [1:0] contVoltSense,
  input wire [1:0] contCurSense,
  input wire selectButton,
  // Same-domain element and link inputs.
  input wire [15:0] anaValue0,
  input wire [15:0] anaValue1,
  input wire sysCycleTick,
  input wire [7:0] remoteIn,
  // Outputs.
  output reg [7:0] virtOut,
  output reg breakerClosed,
  output reg poleDisagree,
  output reg recallActive,
  output reg breakerSelected
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_FETCH = 3'b010;
  localparam [2:0] ST_EXEC = 3'b100;

  reg [8:0] ctrl;
  reg [31:0] alarmDelay;
  reg [31:0] recallTime;
  reg [5:0] sboTimeout;
  reg [7:0] virtIn;
  reg [5:0] progAddr;
  reg [16:0] anaSet0;
  reg [16:0] anaSet1;
  reg [31:0] elemTime;
  reg [15:0] cntSet;
  reg [15:0] digSel;
  reg [15:0] eqTime;
  reg [15:0] pulseCount;
  reg prevCount;
  reg [31:0] msCount;
  reg msTick;
  reg [9:0] secCount;
  reg secTick;
  reg [31:0] alarmCount;
  reg [31:0] recallCount;
  reg [5:0] sboCount;
  reg prevSelect;
  reg [1:0] digPick;
  reg [2:0] state;
  reg [5:0] pc;
  reg acc;
  reg [1:0] latchQ;
  reg [1:0] eqTimerIn;
  reg passDone;
  reg [7:0] passCount;
  reg [7:0] lastPasses;
  wire [15:0] inst;
  wire [3:0] instOp = inst[15:12];
  wire [7:0] instArg = inst[7:0];
  wire [63:0] opVec;
  wire operand;
  wire [8:0] pinStable;
  wire [3:0] elemPick;
  wire [3:0] elemOp;
  wire [1:0] eqTimerOut;
  wire [1:0] anaPick;
  wire progWr = regWr && (regAddr == `REG_PROG_DATA);
  wire ctrlWr = regWr && (regAddr == `REG_CTRL);
  wire manualCloseCmd = ctrlWr && regWrData[`CTRL_MAN_CLOSE];
  wire deselectCmd = ctrlWr && regWrData[`CTRL_DESELECT];
  wire countClearCmd = ctrlWr && regWrData[`CTRL_CNT_CLR];
  wire [2:0] poles = pinStable[2:0];
  wire onePole = ctrl[`CTRL_ONE_POLE];
  wire brkEn = ctrl[`CTRL_BRK_EN];
  wire selectPress = pinStable[8] && !prevSelect;
  genvar g;

  // Field pins pass three flops; a new level is taken once the last two agree.
  wire [8:0] pinRaw = {selectButton, contCurSense, contVoltSense, contIn};
  generate
    for (g = 0; g < 9; g = g + 1) begin : g_sync
      reg s1;
      reg s2;
      reg s3;
      reg stable;
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          stable <= 1'b0;
        end else begin
          s1 <= pinRaw[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            stable <= s3;
          end
        end
      end
      assign pinStable[g] = stable;
    end
  endgenerate

  // Analog comparators; a forced block suppresses pickup.
  assign anaPick[0] = !ctrl[`CTRL_BLK0] && (anaSet0[`ANA_DIR_BIT] ?
    (anaValue0 < anaSet0[15:0]) : (anaValue0 > anaSet0[15:0]));
  assign anaPick[1] = !ctrl[`CTRL_BLK1] && (anaSet1[`ANA_DIR_BIT] ?
    (anaValue1 < anaSet1[15:0]) : (anaValue1 > anaSet1[15:0]));
  assign elemPick = {digPick, anaPick};

  // Pickup/reset timers shared in form by analog and digital elements, in ms steps.
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_elem
      reg [15:0] tcnt;
      reg op;
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          tcnt <= 16'h0;
          op <= 1'b0;
        end else if (elemPick[g] == op) begin
          tcnt <= 16'h0;
        end else if (msTick) begin
          if (tcnt >= (op ? elemTime[31:16] : elemTime[15:0])) begin
            op <= elemPick[g];
            tcnt <= 16'h0;
          end else begin
            tcnt <= tcnt + 16'h1;
          end
        end
      end
      assign elemOp[g] = op;
    end
  endgenerate

  // Equation on-delay timers run continuously on the level the last pass gave them.
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_eqtmr
      reg [15:0] tcnt;
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          tcnt <= 16'h0;
        end else if (!eqTimerIn[g]) begin
          tcnt <= 16'h0;
        end else if (msTick && tcnt < eqTime) begin
          tcnt <= tcnt + 16'h1;
        end
      end
      assign eqTimerOut[g] = eqTimerIn[g] && (tcnt >= eqTime);
    end
  endgenerate

  // Operand space: every flag is one bit, one meaning set.
  assign opVec[1:0] = 2'b10;
  assign opVec[5:2] = pinStable[3:0];
  assign opVec[9:6] = ~pinStable[3:0];
  assign opVec[13:10] = {~pinStable[6], pinStable[6], ~pinStable[4], pinStable[4]};
  assign opVec[17:14] = {~pinStable[7], pinStable[7], ~pinStable[5], pinStable[5]};
  assign opVec[21:18] = {ctrl[`CTRL_BLK0], elemOp[0], ~anaPick[0], anaPick[0]};
  assign opVec[25:22] = {ctrl[`CTRL_BLK1], elemOp[1], ~anaPick[1], anaPick[1]};
  assign opVec[28:26] = {elemOp[2], ~digPick[0], digPick[0]};
  assign opVec[31:29] = {elemOp[3], ~digPick[1], digPick[1]};
  assign opVec[34:32] = {pulseCount < cntSet, pulseCount == cntSet,
    pulseCount > cntSet};
  assign opVec[38:35] = {breakerClosed, breakerSelected, recallActive, poleDisagree};
  assign opVec[39] = 1'b0;
  assign opVec[47:40] = virtIn;
  assign opVec[55:48] = remoteIn;
  assign opVec[63:56] = virtOut;
  assign operand = (instArg[7:6] == 2'b00) ? opVec[instArg[5:0]] : 1'b0;

  // Digital element inputs are registered to keep the operand mux free of loops.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      digPick <= 2'b00;
    end else begin
      digPick[0] <= opVec[digSel[5:0]];
      digPick[1] <= opVec[digSel[13:8]];
    end
  end

  // Pulse counter on contact input 3 rising edges.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pulseCount <= 16'h0;
      prevCount <= 1'b0;
    end else begin
      prevCount <= pinStable[3];
      if (pinStable[3] && !prevCount && pulseCount != 16'hffff) begin
        pulseCount <= pulseCount + 16'h1;
      end else if (countClearCmd) begin
        pulseCount <= 16'h0;
      end
    end
  end

  // Millisecond and second ticks for every timer in the block.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      msCount <= 32'h0;
      msTick <= 1'b0;
      secCount <= 10'h0;
      secTick <= 1'b0;
    end else begin
      msTick <= (msCount == MS_CYCLES - 1);
      secTick <= 1'b0;
      if (msCount == MS_CYCLES - 1) begin
        msCount <= 32'h0;
      end else begin
        msCount <= msCount + 32'h1;
      end
      if (msTick) begin
        if (secCount == `MS_PER_S - 1) begin
          secCount <= 10'h0;
          secTick <= 1'b1;
        end else begin
          secCount <= secCount + 10'h1;
        end
      end
    end
  end

  // Breaker position, pole disagreement and manual close recall.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      breakerClosed <= 1'b0;
      poleDisagree <= 1'b0;
      alarmCount <= 32'h0;
      recallCount <= 32'h0;
      recallActive <= 1'b0;
    end else begin
      breakerClosed <= onePole ? (&poles) : poles[0];
      if (!brkEn || !onePole || (&poles) || !(|poles)) begin
        alarmCount <= 32'h0;
        poleDisagree <= 1'b0;
      end else if (alarmCount >= alarmDelay) begin
        poleDisagree <= 1'b1;
      end else if (msTick) begin
        alarmCount <= alarmCount + 32'h1;
      end
      if (manualCloseCmd && brkEn) begin
        recallCount <= recallTime;
        recallActive <= 1'b1;
      end else if (recallActive && msTick) begin
        if (recallCount == 32'h0) begin
          recallActive <= 1'b0;
        end else begin
          recallCount <= recallCount - 32'h1;
        end
      end
    end
  end

  // Select-before-operate; a new press wins over a same-cycle deselect.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      breakerSelected <= 1'b0;
      sboCount <= 6'h0;
      prevSelect <= 1'b0;
    end else begin
      prevSelect <= pinStable[8];
      if (selectPress && brkEn) begin
        breakerSelected <= 1'b1;
        sboCount <= sboTimeout;
      end else if (deselectCmd) begin
        breakerSelected <= 1'b0;
      end else if (breakerSelected && secTick && ctrl[`CTRL_PB_EN]) begin
        if (sboCount <= 6'h1) begin
          breakerSelected <= 1'b0;
        end
        sboCount <= sboCount - 6'h1;
      end
    end
  end

  equation_store u_store (
    .clk(clk),
    .wrEn(progWr),
    .wrAddr(progAddr),
    .wrData(regWrData[15:0]),
    .rdAddr(pc),
    .rdData(inst)
  );

  // Sequencer: one instruction every two cycles, passes restart after one idle cycle.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      pc <= 6'h0;
      acc <= 1'b0;
      virtOut <= 8'h0;
      latchQ <= 2'b00;
      eqTimerIn <= 2'b00;
      passDone <= 1'b0;
    end else begin
      passDone <= 1'b0;
      case (state)
        ST_IDLE: begin
          pc <= 6'h0;
          acc <= 1'b0;
          if (ctrl[`CTRL_RUN]) begin
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state <= ST_EXEC;
        end
        ST_EXEC: begin
          pc <= pc + 6'h1;
          state <= (pc == 6'h3f) ? ST_IDLE : ST_FETCH;
          passDone <= (pc == 6'h3f) || (instOp == `OPC_END) || (instOp > `OPC_STORE);
          case (instOp)
            `OPC_LOAD: acc <= operand;
            `OPC_AND: acc <= acc & operand;
            `OPC_OR: acc <= acc | operand;
            `OPC_XOR: acc <= acc ^ operand;
            `OPC_NOT: acc <= ~acc;
            `OPC_TIMER: begin
              eqTimerIn[instArg[6]] <= acc;
              acc <= eqTimerOut[instArg[6]];
            end
            `OPC_LATCH: begin
              latchQ[inst[8]] <= (latchQ[inst[8]] | acc) & ~operand;
              acc <= (latchQ[inst[8]] | acc) & ~operand;
            end
            `OPC_STORE: virtOut[instArg[2:0]] <= acc;
            default: state <= ST_IDLE;
          endcase
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Pass rate per power cycle; the engine needs at most 129 cycles per pass.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      passCount <= 8'h0;
      lastPasses <= 8'h0;
    end else if (sysCycleTick) begin
      lastPasses <= passCount;
      passCount <= {7'h0, passDone};
    end else if (passDone && passCount != 8'hff) begin
      passCount <= passCount + 8'h1;
    end
  end

  // Register writes.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= 9'h0;
      alarmDelay <= 32'h0;
      recallTime <= 32'h0;
      sboTimeout <= `SBO_TIMEOUT_RST;
      virtIn <= 8'h0;
      progAddr <= 6'h0;
      anaSet0 <= 17'h0;
      anaSet1 <= 17'h0;
      elemTime <= 32'h0;
      cntSet <= 16'h0;
      digSel <= 16'h0;
      eqTime <= 16'h0;
    end else if (regWr) begin
      if (regAddr == `REG_CTRL) begin
        ctrl <= regWrData[8:0] & 9'h1a7;
      end else if (regAddr == `REG_ALARM_DELAY) begin
        alarmDelay <= regWrData;
      end else if (regAddr == `REG_RECALL_TIME) begin
        recallTime <= regWrData;
      end else if (regAddr == `REG_SBO_TIMEOUT) begin
        sboTimeout <= regWrData[5:0];
      end else if (regAddr == `REG_VIRT_IN) begin
        virtIn <= regWrData[7:0];
      end else if (regAddr == `REG_PROG_ADDR) begin
        progAddr <= regWrData[5:0];
      end else if (regAddr == `REG_PROG_DATA) begin
        progAddr <= progAddr + 6'h1;
      end else if (regAddr == `REG_ANA0_SET) begin
        anaSet0 <= regWrData[16:0];
      end else if (regAddr == `REG_ANA1_SET) begin
        anaSet1 <= regWrData[16:0];
      end else if (regAddr == `REG_ELEM_TIME) begin
        elemTime <= regWrData;
      end else if (regAddr == `REG_CNT_SET) begin
        cntSet <= regWrData[15:0];
      end else if (regAddr == `REG_DIG_SEL) begin
        digSel <= regWrData[15:0] & 16'h3f3f;
      end else if (regAddr == `REG_EQ_TIME) begin
        eqTime <= regWrData[15:0];
      end
    end
  end

  // Register reads, answered in the cycle after the strobe; unmapped reads return zero.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdData <= 32'h0;
    end else if (!regRd) begin
      regRdData <= 32'h0;
    end else if (regAddr == `REG_CTRL) begin
      regRdData <= {23'h0, ctrl};
    end else if (regAddr == `REG_ALARM_DELAY) begin
      regRdData <= alarmDelay;
    end else if (regAddr == `REG_RECALL_TIME) begin
      regRdData <= recallTime;
    end else if (regAddr == `REG_SBO_TIMEOUT) begin
      regRdData <= {26'h0, sboTimeout};
    end else if (regAddr == `REG_VIRT_IN) begin
      regRdData <= {24'h0, virtIn};
    end else if (regAddr == `REG_STATUS) begin
      regRdData <= {16'h0, lastPasses, 3'h0, (lastPasses >= `MIN_PASSES), breakerSelected,
        recallActive, poleDisagree, breakerClosed};
    end else if (regAddr == `REG_VIRT_OUT) begin
      regRdData <= {24'h0, virtOut};
    end else if (regAddr == `REG_FLAGS_LO) begin
      regRdData <= opVec[31:0];
    end else if (regAddr == `REG_FLAGS_HI) begin
      regRdData <= opVec[63:32];
    end else if (regAddr == `REG_PROG_ADDR) begin
      regRdData <= {26'h0, progAddr};
    end else if (regAddr == `REG_ANA0_SET) begin
      regRdData <= {15'h0, anaSet0};
    end else if (regAddr == `REG_ANA1_SET) begin
      regRdData <= {15'h0, anaSet1};
    end else if (regAddr == `REG_ELEM_TIME) begin
      regRdData <= elemTime;
    end else if (regAddr == `REG_CNT_SET) begin
      regRdData <= {16'h0, cntSet};
    end else if (regAddr == `REG_DIG_SEL) begin
      regRdData <= {16'h0, digSel};
    end else if (regAddr == `REG_EQ_TIME) begin
      regRdData <= {16'h0, eqTime};
    end else if (regAddr == `REG_COUNT) begin
      regRdData <= {16'h0, pulseCount};
    end else begin
      regRdData <= 32'h0;
    end
  end

endmodule // relay_logic_equation_engine

// [pkg/relay_logic_map.vh]
// Register offsets, field positions, reset values, opcodes and timing for the logic engine.
`ifndef RELAY_LOGIC_MAP_VH
`define RELAY_LOGIC_MAP_VH

// Register byte offsets.
`define REG_CTRL 8'h00
`define REG_ALARM_DELAY 8'h04
`define REG_RECALL_TIME 8'h08
`define REG_SBO_TIMEOUT 8'h0c
`define REG_VIRT_IN 8'h10
`define REG_STATUS 8'h14
`define REG_VIRT_OUT 8'h18
`define REG_FLAGS_LO 8'h1c
`define REG_FLAGS_HI 8'h20
`define REG_PROG_ADDR 8'h24
`define REG_PROG_DATA 8'h28
`define REG_ANA0_SET 8'h2c
`define REG_ANA1_SET 8'h30
`define REG_ELEM_TIME 8'h34
`define REG_CNT_SET 8'h38
`define REG_DIG_SEL 8'h3c
`define REG_EQ_TIME 8'h40
`define REG_COUNT 8'h44

// Control register fields, then the direction bit of the analog set registers.
`define CTRL_BRK_EN 0
`define CTRL_PB_EN 1
`define CTRL_ONE_POLE 2
`define CTRL_MAN_CLOSE 3
`define CTRL_DESELECT 4
`define CTRL_RUN 5
`define CTRL_CNT_CLR 6
`define CTRL_BLK0 7
`define CTRL_BLK1 8
`define ANA_DIR_BIT 16

// Reset values.
`define SBO_TIMEOUT_RST 6'h1e

// Status register fields.
`define ST_CLOSED 0
`define ST_DISAGREE 1
`define ST_RECALL 2
`define ST_SELECTED 3
`define ST_RATE_OK 4

// Equation opcodes in bits 15:12 of an instruction.
`define OPC_END 4'h0
`define OPC_LOAD 4'h1
`define OPC_AND 4'h2
`define OPC_OR 4'h3
`define OPC_XOR 4'h4
`define OPC_NOT 4'h5
`define OPC_TIMER 4'h6
`define OPC_LATCH 4'h7
`define OPC_STORE 4'h8

// Operand index bases.
`define OPD_CIN_ON 6'h02
`define OPD_CIN_OFF 6'h06
`define OPD_VIN 6'h28
`define OPD_RIN 6'h30
`define OPD_VOUT 6'h38

// Timing.
`define CLK_PERIOD_NS 5
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define MS_PER_S 1000
`define MIN_PASSES 4

`endif

// [rtl/equation_store.v]
// Program memory holding the equation instructions, registered read.
`timescale 1ns/10ps
module equation_store (
  // Clock.
  input wire clk,
  // Write port.
  input wire wrEn,
  input wire [5:0] wrAddr,
  input wire [15:0] wrData,
  // Read port.
  input wire [5:0] rdAddr,
  output reg [15:0] rdData
);

  reg [15:0] mem [0:63];

  // Memory has no reset; software loads the program before enabling evaluation.
  always @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule // equation_store

// [dv/relay_logic_equation_engine_sva.sv]
// Port-level assertions for the relay logic engine.
`timescale 1ns/10ps
`include "relay_logic_map.vh"
module relay_logic_equation_engine_sva #(
  parameter MS_CYCLES = 10
) (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // Register port.
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [31:0] regRdData,
  // Pins and outputs.
  input wire [3:0] contIn,
  input wire selectButton,
  input wire [7:0] virtOut,
  input wire poleDisagree,
  input wire recallActive,
  input wire breakerSelected
);
  reg [8:0] ctrl;
  reg [7:0] idle;
  wire ctrlWr = regWr && regAddr == `REG_CTRL;
  // Stored control bits; command bits are never kept.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= 9'h000;
    end else if (ctrlWr) begin
      ctrl <= regWrData[8:0] & 9'h1a7;
    end
  end
  // Cycles with run off; 200 outlasts any pass still in flight.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle <= 8'h00;
    end else if (ctrl[`CTRL_RUN]) begin
      idle <= 8'h00;
    end else if (idle != 8'hc8) begin
      idle <= idle + 8'h01;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_rd(a);
    regRd && regAddr == a;
  endsequence
  sequence s_man_close;
    ctrlWr && regWrData[`CTRL_MAN_CLOSE] && regWrData[0] && ctrl[0];
  endsequence
  sequence s_press;
    ctrl[0] && !selectButton ##1 selectButton;
  endsequence
  property p_rd_idle;
    !regRd |=> regRdData == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
  property p_vout_read;
    s_rd(`REG_VIRT_OUT) |=> regRdData == {24'h0, $past(virtOut)};
  endproperty
  a_vout_read: assert property (p_vout_read) else $error("virtual output read");
  property p_no_disagree;
    (contIn[2:0] == 3'b000 || contIn[2:0] == 3'b111) [*8] |=> !poleDisagree;
  endproperty
  a_no_disagree: assert property (p_no_disagree) else $error("disagree with poles equal");
  property p_recall;
    s_man_close |-> ##[1:4] recallActive;
  endproperty
  a_recall: assert property (p_recall) else $error("recall not started");
  property p_select;
    s_press |-> ##[2:8] breakerSelected;
  endproperty
  a_select: assert property (p_select) else $error("select not taken");
  property p_sel_hold;
    breakerSelected && ctrl[0] && !ctrl[1] && !ctrlWr && !$past(ctrlWr) |=> breakerSelected;
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selection dropped");
  property p_vout_stable;
    idle == 8'hc8 |=> $stable(virtOut);
  endproperty
  a_vout_stable: assert property (p_vout_stable) else $error("virtual output moved");
  property p_flag_pairs;
    s_rd(`REG_FLAGS_LO) |=> regRdData[1:0] == 2'b10 && regRdData[9:6] == ~regRdData[5:2]
      && regRdData[11] != regRdData[10] && regRdData[13] != regRdData[12]
      && regRdData[19] != regRdData[18] && regRdData[23] != regRdData[22]
      && regRdData[27] != regRdData[26] && regRdData[30] != regRdData[29];
  endproperty
  a_flag_pairs: assert property (p_flag_pairs) else $error("flag pair not inverse");
  property p_cnt;
    s_rd(`REG_FLAGS_HI) |=> $onehot(regRdData[2:0]);
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter flags not exclusive");
endmodule // relay_logic_equation_engine_sva

// [dv/relay_field_model.sv]
// Far side: power-system cycle tick and a peer relay on the link.
`timescale 1ns/10ps
module relay_field_model #(
  parameter TICK = 1000
) (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // Peer link and cycle tick.
  input wire [7:0] virtOut,
  output reg [7:0] remoteIn,
  output reg sysCycleTick
);
  reg [15:0] count;
  // The peer echoes our outputs one cycle late, as a distributed scheme would.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= 16'h0000;
      sysCycleTick <= 1'b0;
      remoteIn <= 8'h00;
    end else begin
      remoteIn <= virtOut;
      sysCycleTick <= (count == TICK - 1);
      count <= (count == TICK - 1) ? 16'h0000 : count + 16'h0001;
    end
  end
endmodule // relay_field_model

// [dv/relay_logic_equation_engine_tb.sv]
// Self-checking bench for the relay logic engine.
`timescale 1ns/10ps
`include "relay_logic_map.vh"
module relay_logic_equation_engine_tb;
  localparam MS = 10;
  localparam [399:0] PROG = {16'h1028, 16'h2029, 16'h8000, 16'h1028, 16'h3029, 16'h8001,
    16'h1028, 16'h4029, 16'h8002, 16'h1028, 16'h5000, 16'h8003, 16'h1001, 16'h8004,
    16'h102a, 16'h702b, 16'h8005, 16'h103e, 16'h302a, 16'h202c, 16'h8006, 16'h102d,
    16'h6000, 16'h8007, 16'h0000};
  // Virtual inputs beside the expected low six virtual outputs; the latch keeps history.
  localparam [127:0] ROWS = {16'h0018, 16'h0116, 16'h021e, 16'h0313, 16'h0438, 16'h0038,
    16'h0c18, 16'h0018};
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [7:0] regAddr = 8'h00;
  reg [31:0] regWrData = 32'h0;
  reg regWr = 1'b0;
  reg regRd = 1'b0;
  reg [3:0] contIn = 4'h0;
  reg [1:0] contVoltSense = 2'b01;
  reg [1:0] contCurSense = 2'b10;
  reg selectButton = 1'b0;
  reg [15:0] anaValue0 = 16'h0100;
  reg [15:0] anaValue1 = 16'h0100;
  wire [31:0] regRdData;
  wire [7:0] virtOut;
  wire [7:0] remoteIn;
  wire sysCycleTick;
  wire breakerClosed;
  wire poleDisagree;
  wire recallActive;
  wire breakerSelected;
  wire [4:0] obs = {virtOut[7:6], poleDisagree, recallActive, breakerSelected};
  reg [31:0] d;
  integer nFail = 0;
  integer checks = 0;
  integer i;
  integer t;
  // Clock at 200 MHz.
  always #2.5 clk = ~clk;
  relay_logic_equation_engine #(.MS_CYCLES(MS)) dut_u (.clk(clk), .resetn(resetn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .contIn(contIn), .contVoltSense(contVoltSense),
    .contCurSense(contCurSense), .selectButton(selectButton), .anaValue0(anaValue0),
    .anaValue1(anaValue1), .sysCycleTick(sysCycleTick), .remoteIn(remoteIn),
    .virtOut(virtOut), .breakerClosed(breakerClosed), .poleDisagree(poleDisagree),
    .recallActive(recallActive), .breakerSelected(breakerSelected));
  relay_field_model #(.TICK(1000)) field_u (.clk(clk), .resetn(resetn), .virtOut(virtOut),
    .remoteIn(remoteIn), .sysCycleTick(sysCycleTick));
  task printVerdict;
    begin
      if (nFail == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        nFail = nFail + 1;
        $display("CHECK FAILED %0t %h %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe, so take them there.
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      d = regRdData;
    end
  endtask
  task pin(input [3:0] c, input s);
    begin
      @(posedge clk);
      contIn <= c;
      selectButton <= s;
    end
  endtask
  task waitObs(input integer b, input lvl, input integer lim);
    begin
      t = 0;
      while (obs[b] !== lvl && t < lim) begin
        @(posedge clk);
        t = t + 1;
      end
      chk(t < lim, 1);
    end
  endtask
  // A hang cuts the run short well past the longest expected sequence.
  initial begin
    #400000;
    nFail = nFail + 1;
    printVerdict;
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    chk(virtOut, 8'h00);
    rd(`REG_SBO_TIMEOUT);
    chk(d, 32'h1e);
    rd(8'hfc);
    chk(d, 32'h0);
    wr(`REG_VIRT_IN, 32'h01);
    repeat (220) @(posedge clk);
    chk(virtOut, 8'h00);
    wr(`REG_PROG_ADDR, 32'h0);
    for (i = 0; i < 25; i = i + 1)
      wr(`REG_PROG_DATA, PROG[(24 - i) * 16 +: 16]);
    wr(`REG_ELEM_TIME, 32'h00030002);
    wr(`REG_EQ_TIME, 32'h2);
    wr(`REG_DIG_SEL, 32'h2d);
    wr(`REG_CNT_SET, 32'h2);
    wr(`REG_ANA0_SET, 32'h100);
    wr(`REG_ANA1_SET, 32'h10100);
    wr(`REG_ALARM_DELAY, 32'h3);
    wr(`REG_RECALL_TIME, 32'h4);
    wr(`REG_SBO_TIMEOUT, 32'h2);
    wr(`REG_CTRL, 32'h21);
    for (i = 0; i < 8; i = i + 1) begin
      wr(`REG_VIRT_IN, ROWS[(7 - i) * 16 + 8 +: 8]);
      // Two full passes, so that a row equal to the last one still proves the new pass.
      repeat (120) @(posedge clk);
      chk(virtOut[5:0], ROWS[(7 - i) * 16 +: 6]);
    end
    rd(`REG_VIRT_OUT);
    chk(d, 32'h18);
    rd(`REG_FLAGS_HI);
    chk(d[31:16], 16'h1818);
    // Seal-in through the output's own feedback.
    wr(`REG_VIRT_IN, 32'h14);
    waitObs(3, 1'b1, 200);
    wr(`REG_VIRT_IN, 32'h10);
    repeat (150) @(posedge clk);
    chk(obs[3], 1'b1);
    wr(`REG_VIRT_IN, 32'h00);
    waitObs(3, 1'b0, 200);
    wr(`REG_VIRT_IN, 32'h20);
    waitObs(4, 1'b1, 300);
    chk(t >= MS, 1);
    repeat (2 * MS) @(posedge clk);
    rd(`REG_FLAGS_LO);
    chk(d[28:26], 3'b101);
    wr(`REG_VIRT_IN, 32'h00);
    repeat (4) @(posedge clk);
    rd(`REG_FLAGS_LO);
    chk(d[28:26], 3'b110);
    repeat (8 * MS) @(posedge clk);
    rd(`REG_FLAGS_LO);
    chk(d, {6'b010010, 16'h2269, 8'hf0, 2'b10});
    @(posedge clk);
    anaValue0 <= 16'h0101;
    anaValue1 <= 16'h00ff;
    repeat (8 * MS) @(posedge clk);
    rd(`REG_FLAGS_LO);
    chk(d[25:18], 8'h55);
    wr(`REG_CTRL, 32'h1a1);
    repeat (4) @(posedge clk);
    rd(`REG_FLAGS_LO);
    chk({d[25], d[21]}, 2'b11);
    wr(`REG_CTRL, 32'h21);
    for (i = 1; i <= 3; i = i + 1) begin
      pin(4'h8, 1'b0);
      repeat (6) @(posedge clk);
      pin(4'h0, 1'b0);
      repeat (6) @(posedge clk);
      rd(`REG_FLAGS_HI);
      chk(d[2:0], (i == 2) ? 3'b010 : ((i > 2) ? 3'b001 : 3'b100));
    end
    wr(`REG_CTRL, 32'h61);
    rd(`REG_FLAGS_HI);
    chk(d[2:0], 3'b100);
    // Single-pole tracking, then three-pole on the same pins.
    wr(`REG_CTRL, 32'h25);
    pin(4'h1, 1'b0);
    waitObs(2, 1'b1, 100);
    chk(t >= 2 * MS, 1);
    chk(breakerClosed, 1'b0);
    pin(4'h7, 1'b0);
    waitObs(2, 1'b0, 10);
    chk(breakerClosed, 1'b1);
    wr(`REG_CTRL, 32'h21);
    pin(4'h1, 1'b0);
    repeat (8 * MS) @(posedge clk);
    chk({breakerClosed, poleDisagree}, 2'b10);
    pin(4'h0, 1'b0);
    wr(`REG_CTRL, 32'h29);
    waitObs(1, 1'b1, 5);
    waitObs(1, 1'b0, 100);
    chk(t >= 3 * MS, 1);
    pin(4'h0, 1'b1);
    waitObs(0, 1'b1, 12);
    pin(4'h0, 1'b0);
    repeat (2100 * MS) @(posedge clk);
    chk(obs[0], 1'b1);
    wr(`REG_CTRL, 32'h31);
    waitObs(0, 1'b0, 5);
    wr(`REG_CTRL, 32'h23);
    pin(4'h0, 1'b1);
    waitObs(0, 1'b1, 12);
    pin(4'h0, 1'b0);
    waitObs(0, 1'b0, 2100 * MS);
    chk(t >= 1000 * MS - 20, 1);
    rd(`REG_STATUS);
    chk({d[4], d[15:8] >= 8'h04}, 2'b11);
    printVerdict;
  end
endmodule // relay_logic_equation_engine_tb
bind relay_logic_equation_engine relay_logic_equation_engine_sva #(.MS_CYCLES(MS_CYCLES)) sva_u (
  .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .contIn(contIn), .selectButton(selectButton),
  .virtOut(virtOut), .poleDisagree(poleDisagree), .recallActive(recallActive),
  .breakerSelected(breakerSelected));
